// ---- ffh_pkg.sv ----
// package: constants and types for the fault flag and halt unit
package ffh_pkg;
  // ------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT = 4'h2;
  localparam logic [3:0] REG_IRQ_CLR = 4'h3;
  localparam logic [3:0] REG_IRQ_EN = 4'h4;
  localparam logic [3:0] REG_HALT_IPTR = 4'h5;
  // ctrl fields
  localparam int unsigned CTRL_HOF_BIT = 0;
  localparam int unsigned CTRL_SETF_BIT = 1;
  // status fields
  localparam int unsigned ST_FAULT_BIT = 0;
  localparam int unsigned ST_HOF_BIT = 1;
  localparam int unsigned ST_HALTED_BIT = 2;
  localparam int unsigned ST_HALT_ANA_BIT = 3;
  localparam int unsigned ST_LINKS_OFF_BIT = 4;
  localparam int unsigned ST_HIPRI_BIT = 5;
  // interrupt events
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_HALT = 1;
  localparam int unsigned EV_LINKS_OFF = 2;
  // instruction pointer offsets at halt
  localparam int unsigned FAULT_IPTR_OFS = 2;
  localparam int unsigned INSPECT_IPTR_OFS = 1;
  // halt states
  typedef enum logic [1:0] {
    FFH_RUN,
    FFH_WAIT_DESCHED,
    FFH_DRAIN,
    FFH_STOPPED
  } ffh_state_t;
endpackage : ffh_pkg

// ---- ffh_flag_if.sv ----
// interface: fault flag core signals between top and flag keeper
`timescale 1ns/1ps
interface ffh_flag_if;
  logic fault_set;
  logic fault_clr;
  logic hof_wr;
  logic hof_wdata;
  logic preempt;
  logic resume;
  logic fault;
  logic hof;
  logic hipri;
  logic fault_rise;
  modport keeper (
    input fault_set, fault_clr, hof_wr, hof_wdata, preempt, resume,
    output fault, hof, hipri, fault_rise
  );
  modport user (
    output fault_set, fault_clr, hof_wr, hof_wdata, preempt, resume,
    input fault, hof, hipri, fault_rise
  );
endinterface : ffh_flag_if

// ---- ffh_flag_keeper.sv ----
// module: fault flag, halt-on-fault enable and pre-emption save
`timescale 1ns/1ps
module ffh_flag_keeper (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // flag port
  ffh_flag_if.keeper fl
);
  logic fault_ff;
  logic nxt_fault;
  logic hof_ff;
  logic nxt_hof;
  logic sv_fault_ff;
  logic nxt_sv_fault;
  logic sv_hof_ff;
  logic nxt_sv_hof;
  logic hipri_ff;
  logic nxt_hipri;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_fault = fault_ff;
    nxt_hof = hof_ff;
    nxt_sv_fault = sv_fault_ff;
    nxt_sv_hof = sv_hof_ff;
    nxt_hipri = hipri_ff;
    if (fl.hof_wr) begin
      nxt_hof = fl.hof_wdata;
    end
    if (fl.fault_clr) begin
      nxt_fault = 1'b0;
    end
    if (fl.preempt && !hipri_ff) begin
      nxt_sv_fault = fault_ff;
      nxt_sv_hof = hof_ff;
      nxt_hof = 1'b0;
      nxt_hipri = 1'b1;
    end else if (fl.resume && hipri_ff) begin
      nxt_fault = sv_fault_ff;
      nxt_hof = sv_hof_ff;
      nxt_hipri = 1'b0;
    end
    if (fl.fault_set) begin
      nxt_fault = 1'b1;
    end
  end

  // flag survives processor reset; only the mode bits reset
  always_ff @(posedge sys_clk_in) begin
    fault_ff <= nxt_fault;
    sv_fault_ff <= nxt_sv_fault;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hof_ff <= 1'b0;
      sv_hof_ff <= 1'b0;
      hipri_ff <= 1'b0;
    end else begin
      hof_ff <= nxt_hof;
      sv_hof_ff <= nxt_sv_hof;
      hipri_ff <= nxt_hipri;
    end
  end

  assign fl.fault = fault_ff;
  assign fl.hof = hof_ff;
  assign fl.hipri = hipri_ff;
  assign fl.fault_rise = nxt_fault && !fault_ff;
endmodule : ffh_flag_keeper

// ---- ffh_fault_halt.sv ----
// module: top of the fault flag and halt unit
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Functional notes
// - fault pin follows the internal fault flag directly
// - overflow, divide by zero, bounds violation or software set the flag
// - the fault-test instruction clears the flag; completion also clears it when the saved flag was clear
// - processor reset leaves the fault flag untouched
// - processes may stop on fault; independent ones stay schedulable
// - flag rising with halt enable set stops all processes
// - enabling halt while flag already set does not halt
// - pre-emption saves flag and enable, completion restores both
// - pre-empting process inherits flag, starts with enable cleared
// - after fault halt, links finish outstanding transfers then shut down
// - during inspection request inputs continue, outputs fetch no data
// - memory refresh continues after a fault halt
// - fault halt leaves pointer two bytes past faulting instruction
// - inspection halt leaves pointer one byte past current instruction
// - both halts copy the pointer into the top stack register
// - inspection request halts at the next descheduling point
module ffh_fault_halt #(
  parameter int unsigned IPTR_W = 32
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire logic [ffh_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // execution unit events
  input wire logic arith_overflow_in,
  input wire logic div_zero_in,
  input wire logic bounds_fault_in,
  input wire logic fault_test_in,
  input wire logic [IPTR_W-1:0] iptr_in,
  input wire logic desched_point_in,
  input wire logic preempt_in,
  input wire logic hipri_done_in,
  input wire logic proc_stops_on_fault_in,
  // links and memory
  input wire logic links_busy_in,
  // inspection pin
  input wire logic external_event_request_in,
  // outputs
  output logic fault_pin_out,
  output logic process_stop_out,
  output logic cpu_halt_out,
  output logic link_out_fetch_en_out,
  output logic link_shutdown_out,
  output logic refresh_en_out,
  output logic top_stack_load_out,
  output logic [IPTR_W-1:0] top_stack_data_out,
  output logic irq_out
);
  initial begin
    if (IPTR_W < 2 || IPTR_W > 32) begin
      $error("IPTR_W must be 2..32");
    end
  end

  ffh_flag_if fl ();

  ffh_flag_keeper u_keeper (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .fl(fl)
  );

  // ------------------------------------------------------------
  // pin synchroniser for inspection request
  // ------------------------------------------------------------
  logic [2:0] ana_sync_ff;
  logic [2:0] nxt_ana_sync;
  logic ana_lvl_ff;
  logic nxt_ana_lvl;

  always_comb begin
    nxt_ana_sync = {ana_sync_ff[1:0], external_event_request_in};
    nxt_ana_lvl = ana_lvl_ff;
    // level moves only once the second and third stages agree
    if (ana_sync_ff[1] == ana_sync_ff[2]) begin
      nxt_ana_lvl = ana_sync_ff[2];
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ana_sync_ff <= 3'h0;
      ana_lvl_ff <= 1'b0;
    end else begin
      ana_sync_ff <= nxt_ana_sync;
      ana_lvl_ff <= nxt_ana_lvl;
    end
  end

  // ------------------------------------------------------------
  // register write decode
  // ------------------------------------------------------------
  function automatic logic wr_hit(
    input logic wr,
    input logic [ffh_pkg::ADDR_W-1:0] addr,
    input logic [ffh_pkg::ADDR_W-1:0] target
  );
    return wr && (addr == target);
  endfunction : wr_hit

  // ------------------------------------------------------------
  // software control register
  // ------------------------------------------------------------
  logic ctrl_wr;
  logic sw_set;
  assign ctrl_wr = wr_hit(reg_wr_in, reg_addr_in, ffh_pkg::REG_CTRL);
  assign sw_set = ctrl_wr && reg_wdata_in[ffh_pkg::CTRL_SETF_BIT];

  assign fl.fault_set = arith_overflow_in || div_zero_in || bounds_fault_in || sw_set;
  assign fl.fault_clr = fault_test_in;
  assign fl.hof_wr = ctrl_wr;
  assign fl.hof_wdata = reg_wdata_in[ffh_pkg::CTRL_HOF_BIT];
  assign fl.preempt = preempt_in;
  assign fl.resume = hipri_done_in;

  // ------------------------------------------------------------
  // halt sequencer
  // ------------------------------------------------------------
  ffh_pkg::ffh_state_t state_ff;
  ffh_pkg::ffh_state_t nxt_state;
  logic by_ana_ff;
  logic nxt_by_ana;
  logic halt_ff;
  logic nxt_halt;
  logic shut_ff;
  logic nxt_shut;
  logic fetch_en_ff;
  logic nxt_fetch_en;
  logic ld_ff;
  logic nxt_ld;
  logic [IPTR_W-1:0] tos_ff;
  logic [IPTR_W-1:0] nxt_tos;
  logic fault_halt;
  logic halt_evt;

  // fault halt only on a rising flag with the enable already set
  assign fault_halt = fl.fault_rise && fl.hof;

  // halt pointer: current pointer plus a byte offset
  function automatic logic [IPTR_W-1:0] halt_ptr(
    input logic [IPTR_W-1:0] ptr,
    input int unsigned ofs
  );
    return ptr + IPTR_W'(ofs);
  endfunction : halt_ptr

  always_comb begin
    nxt_state = state_ff;
    nxt_by_ana = by_ana_ff;
    nxt_halt = halt_ff;
    nxt_shut = shut_ff;
    nxt_fetch_en = fetch_en_ff;
    nxt_ld = 1'b0;
    nxt_tos = tos_ff;
    halt_evt = 1'b0;
    unique case (state_ff)
      ffh_pkg::FFH_RUN: begin
        if (fault_halt) begin
          nxt_state = ffh_pkg::FFH_DRAIN;
          nxt_halt = 1'b1;
          nxt_by_ana = 1'b0;
          nxt_tos = halt_ptr(iptr_in, ffh_pkg::FAULT_IPTR_OFS);
          nxt_ld = 1'b1;
          halt_evt = 1'b1;
        end else if (ana_lvl_ff) begin
          nxt_state = ffh_pkg::FFH_WAIT_DESCHED;
          nxt_fetch_en = 1'b0;
        end
      end
      ffh_pkg::FFH_WAIT_DESCHED: begin
        if (fault_halt) begin
          nxt_state = ffh_pkg::FFH_DRAIN;
          nxt_halt = 1'b1;
          nxt_by_ana = 1'b0;
          nxt_tos = halt_ptr(iptr_in, ffh_pkg::FAULT_IPTR_OFS);
          nxt_ld = 1'b1;
          halt_evt = 1'b1;
        end else if (desched_point_in) begin
          nxt_state = ffh_pkg::FFH_DRAIN;
          nxt_halt = 1'b1;
          nxt_by_ana = 1'b1;
          nxt_tos = halt_ptr(iptr_in, ffh_pkg::INSPECT_IPTR_OFS);
          nxt_ld = 1'b1;
          halt_evt = 1'b1;
        end
      end
      ffh_pkg::FFH_DRAIN: begin
        if (!links_busy_in) begin
          nxt_state = ffh_pkg::FFH_STOPPED;
          nxt_shut = 1'b1;
          nxt_fetch_en = 1'b0;
        end
      end
      ffh_pkg::FFH_STOPPED: begin
        nxt_state = ffh_pkg::FFH_STOPPED;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= ffh_pkg::FFH_RUN;
      by_ana_ff <= 1'b0;
      halt_ff <= 1'b0;
      shut_ff <= 1'b0;
      fetch_en_ff <= 1'b1;
      ld_ff <= 1'b0;
      tos_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      by_ana_ff <= nxt_by_ana;
      halt_ff <= nxt_halt;
      shut_ff <= nxt_shut;
      fetch_en_ff <= nxt_fetch_en;
      ld_ff <= nxt_ld;
      tos_ff <= nxt_tos;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic [ffh_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [ffh_pkg::IRQ_W-1:0] nxt_irq_stat;
  logic [ffh_pkg::IRQ_W-1:0] irq_en_ff;
  logic [ffh_pkg::IRQ_W-1:0] nxt_irq_en;
  logic irq_ff;
  logic nxt_irq;
  logic [ffh_pkg::IRQ_W-1:0] ev;

  always_comb begin
    ev = '0;
    ev[ffh_pkg::EV_FAULT] = fl.fault_rise;
    ev[ffh_pkg::EV_HALT] = halt_evt;
    ev[ffh_pkg::EV_LINKS_OFF] = nxt_shut && !shut_ff;
    nxt_irq_stat = irq_stat_ff;
    if (wr_hit(reg_wr_in, reg_addr_in, ffh_pkg::REG_IRQ_CLR)) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata_in[ffh_pkg::IRQ_W-1:0];
    end
    nxt_irq_stat = nxt_irq_stat | ev;
    nxt_irq_en = irq_en_ff;
    if (wr_hit(reg_wr_in, reg_addr_in, ffh_pkg::REG_IRQ_EN)) begin
      nxt_irq_en = reg_wdata_in[ffh_pkg::IRQ_W-1:0];
    end
    nxt_irq = |(nxt_irq_stat & nxt_irq_en);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat_ff <= '0;
      irq_en_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_en_ff <= nxt_irq_en;
      irq_ff <= nxt_irq;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        ffh_pkg::REG_CTRL: nxt_rdata[ffh_pkg::CTRL_HOF_BIT] = fl.hof;
        ffh_pkg::REG_STATUS: begin
          nxt_rdata[ffh_pkg::ST_FAULT_BIT] = fl.fault;
          nxt_rdata[ffh_pkg::ST_HOF_BIT] = fl.hof;
          nxt_rdata[ffh_pkg::ST_HALTED_BIT] = halt_ff;
          nxt_rdata[ffh_pkg::ST_HALT_ANA_BIT] = by_ana_ff;
          nxt_rdata[ffh_pkg::ST_LINKS_OFF_BIT] = shut_ff;
          nxt_rdata[ffh_pkg::ST_HIPRI_BIT] = fl.hipri;
        end
        ffh_pkg::REG_IRQ_STAT: nxt_rdata[ffh_pkg::IRQ_W-1:0] = irq_stat_ff;
        ffh_pkg::REG_IRQ_EN: nxt_rdata[ffh_pkg::IRQ_W-1:0] = irq_en_ff;
        ffh_pkg::REG_HALT_IPTR: nxt_rdata[IPTR_W-1:0] = tos_ff;
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------
  // pin outputs, each from a flip-flop
  // ------------------------------------------------------------
  logic pstop_ff;
  logic nxt_pstop;
  assign nxt_pstop = proc_stops_on_fault_in && fl.fault;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pstop_ff <= 1'b0;
    end else begin
      pstop_ff <= nxt_pstop;
    end
  end

  // refresh keeps running through any halt
  logic refresh_ff;
  logic nxt_refresh;
  assign nxt_refresh = 1'b1;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      refresh_ff <= 1'b1;
    end else begin
      refresh_ff <= nxt_refresh;
    end
  end

  assign fault_pin_out = fl.fault;
  assign process_stop_out = pstop_ff;
  assign cpu_halt_out = halt_ff;
  assign link_out_fetch_en_out = fetch_en_ff;
  assign link_shutdown_out = shut_ff;
  assign refresh_en_out = refresh_ff;
  assign top_stack_load_out = ld_ff;
  assign top_stack_data_out = tos_ff;
  assign irq_out = irq_ff;
  assign reg_rdata_out = rdata_ff;
endmodule : ffh_fault_halt

// ---- ffh_fault_halt_props.sv ----
// checker: port assertions of the fault flag and halt unit
`timescale 1ns/1ps
module ffh_fault_halt_chk #(
  parameter int unsigned IPTR_W = 32
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // watched inputs
  input wire logic reg_wr_in,
  input wire logic arith_overflow_in,
  input wire logic div_zero_in,
  input wire logic bounds_fault_in,
  input wire logic fault_test_in,
  input wire logic [IPTR_W-1:0] iptr_in,
  input wire logic hipri_done_in,
  input wire logic proc_stops_on_fault_in,
  input wire logic links_busy_in,
  // watched outputs
  input wire logic fault_pin_out,
  input wire logic process_stop_out,
  input wire logic cpu_halt_out,
  input wire logic link_shutdown_out,
  input wire logic refresh_en_out,
  input wire logic top_stack_load_out,
  input wire logic [IPTR_W-1:0] top_stack_data_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_fault_sets: assert property (
    (arith_overflow_in || div_zero_in || bounds_fault_in) |=> fault_pin_out) else $error("fault pin not set");
  chk_test_clears: assert property (
    fault_test_in && !arith_overflow_in && !div_zero_in && !bounds_fault_in && !reg_wr_in && !hipri_done_in
    |=> !fault_pin_out) else $error("fault pin not cleared");
  chk_fault_holds: assert property (
    fault_pin_out && !fault_test_in && !hipri_done_in |=> fault_pin_out) else $error("fault pin dropped");
  chk_stop_follows: assert property (
    proc_stops_on_fault_in && fault_pin_out |=> process_stop_out) else $error("process not stopped");
  chk_halt_sticky: assert property (
    cpu_halt_out |=> cpu_halt_out) else $error("halt released");
  chk_halt_loads: assert property (
    $rose(cpu_halt_out) |-> top_stack_load_out ##1 !top_stack_load_out) else $error("stack load wrong");
  chk_fault_iptr: assert property (
    $rose(cpu_halt_out) && $rose(fault_pin_out)
    |-> top_stack_data_out == IPTR_W'($past(iptr_in) + ffh_pkg::FAULT_IPTR_OFS)) else $error("halt pointer wrong");
  chk_refresh_on: assert property (
    refresh_en_out) else $error("refresh stopped");
  chk_shut_drained: assert property (
    $rose(link_shutdown_out) |-> cpu_halt_out && !$past(links_busy_in)) else $error("links shut early");
endmodule : ffh_fault_halt_chk

bind ffh_fault_halt ffh_fault_halt_chk #(.IPTR_W(IPTR_W)) u_ffh_fault_halt_chk (
  .sys_clk_in, .rst_n_in, .reg_wr_in, .arith_overflow_in, .div_zero_in, .bounds_fault_in,
  .fault_test_in, .iptr_in, .hipri_done_in, .proc_stops_on_fault_in, .links_busy_in,
  .fault_pin_out, .process_stop_out, .cpu_halt_out, .link_shutdown_out, .refresh_en_out,
  .top_stack_load_out, .top_stack_data_out
);

// ---- ffh_supervisor.sv ----
// model: supervisory logic watching the fault pin
`timescale 1ns/1ps
module ffh_supervisor (
  // clock
  input wire logic sys_clk_in,
  // inputs
  input wire logic fault_pin_in,
  input wire logic inspect_in,
  // outputs
  output logic inspect_req_out,
  output logic fault_seen_out
);
  always_ff @(posedge sys_clk_in) begin
    fault_seen_out <= (fault_pin_in === 1'b1);
    inspect_req_out <= inspect_in;
  end
endmodule : ffh_supervisor

// ---- testbench.sv ----
// testbench: fault flag and halt unit
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic [31:0] iptr = 32'h0;
  logic stops = 1'b0;
  logic busy = 1'b0;
  logic insp = 1'b0;
  logic insp_req, seen, pin, pstop, halt, fetch, shut, refr, load, irq;
  logic [31:0] rdata;
  logic [31:0] tdata;
  logic [31:0] v;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;

  ffh_fault_halt u_ffh_fault_halt (
    .sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .arith_overflow_in(ev[0]),
    .div_zero_in(ev[1]), .bounds_fault_in(ev[2]), .fault_test_in(ev[3]), .iptr_in(iptr),
    .desched_point_in(ev[4]), .preempt_in(ev[5]), .hipri_done_in(ev[6]),
    .proc_stops_on_fault_in(stops), .links_busy_in(busy), .external_event_request_in(insp_req),
    .fault_pin_out(pin), .process_stop_out(pstop), .cpu_halt_out(halt),
    .link_out_fetch_en_out(fetch), .link_shutdown_out(shut), .refresh_en_out(refr),
    .top_stack_load_out(load), .top_stack_data_out(tdata), .irq_out(irq)
  );
  ffh_supervisor u_ffh_supervisor (
    .sys_clk_in(clk), .fault_pin_in(pin), .inspect_in(insp),
    .inspect_req_out(insp_req), .fault_seen_out(seen)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test;
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wait_cyc

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(negedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_reg

  task automatic pulse(input logic [6:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    @(negedge clk);
  endtask : pulse

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
  endtask : do_reset

  // timeout
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    do_reset();
    wr_reg(ffh_pkg::REG_CTRL, 32'h2);
    cmp("fault_pin", 32'h1, pin);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'h1, v & 32'h1);
    cmp("irq masked", 32'h0, irq);
    cmp("monitor", 32'h1, seen);
    do_reset();
    cmp("fault_pin", 32'h1, pin);
    pulse(7'h08);
    cmp("fault_pin", 32'h0, pin);
    for (int k = 0; k < 3; k++) begin
      pulse(7'(1 << k));
      wait_cyc(2);
      cmp("fault_pin", 32'h1, pin);
      pulse(7'h08);
    end
    pulse(7'h09);
    cmp("fault_pin", 32'h1, pin);
    pulse(7'h08);
    @(posedge clk);
    stops <= 1'b1;
    pulse(7'h02);
    wait_cyc(1);
    cmp("process_stop", 32'h1, pstop);
    pulse(7'h08);
    wait_cyc(1);
    cmp("process_stop", 32'h0, pstop);
    pulse(7'h04);
    wr_reg(ffh_pkg::REG_CTRL, 32'h1);
    pulse(7'h04);
    wait_cyc(1);
    cmp("cpu_halt", 32'h0, halt);
    pulse(7'h08);
    pulse(7'h20);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'h20, v & 32'h23);
    pulse(7'h01);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'h21, v & 32'h23);
    cmp("cpu_halt", 32'h0, halt);
    pulse(7'h40);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'h02, v & 32'h23);
    wr_reg(ffh_pkg::REG_IRQ_EN, 32'h7);
    @(posedge clk);
    busy <= 1'b1;
    iptr <= 32'h100;
    pulse(7'h01);
    cmp("cpu_halt", 32'h1, halt);
    cmp("stack_load", 32'h1, load);
    cmp("stack_data", 32'h102, tdata);
    wait_cyc(4);
    cmp("shutdown", 32'h0, shut);
    @(posedge clk);
    busy <= 1'b0;
    wait_cyc(3);
    cmp("shutdown", 32'h1, shut);
    cmp("refresh", 32'h1, refr);
    rd_reg(ffh_pkg::REG_HALT_IPTR, v);
    cmp("halt_iptr", 32'h102, v);
    rd_reg(ffh_pkg::REG_IRQ_STAT, v);
    cmp("irq_stat", 32'h7, v);
    cmp("irq_out", 32'h1, irq);
    wr_reg(ffh_pkg::REG_IRQ_CLR, 32'h7);
    rd_reg(ffh_pkg::REG_IRQ_STAT, v);
    cmp("irq_stat", 32'h0, v);
    cmp("irq_out", 32'h0, irq);
    rd_reg(4'hf, v);
    cmp("unmapped", 32'h0, v);
    do_reset();
    cmp("fault_pin", 32'h1, pin);
    pulse(7'h20);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'h21, v & 32'h23);
    pulse(7'h40);
    cmp("fault_pin", 32'h1, pin);
    pulse(7'h08);
    @(posedge clk);
    iptr <= 32'h200;
    insp <= 1'b1;
    wait_cyc(8);
    cmp("fetch_en", 32'h0, fetch);
    cmp("cpu_halt", 32'h0, halt);
    pulse(7'h10);
    cmp("cpu_halt", 32'h1, halt);
    cmp("stack_load", 32'h1, load);
    cmp("stack_data", 32'h201, tdata);
    rd_reg(ffh_pkg::REG_STATUS, v);
    cmp("status", 32'hc, v & 32'hc);
    finish_test();
  end
endmodule : testbench
